// >>> verif/pbc_chk_assertions.sv
// assertions on the power budget register port
// bound to pbc_power_budget, sees its ports only
`timescale 1ns/1ns
module pbc_chk (
  input wire        core_clk,
  input wire        rstn,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [7:0]  budget_sel
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire rh  = reg_rd && reg_addr == 12'h20C;
  wire rd4 = reg_rd && reg_addr == 12'h214;
  wire sw  = reg_wr && reg_addr == 12'h210;
  a_hdr_id: assert property (rh |=> reg_rdata[15:0] == 16'h0004)
    else $error("bad cap id");
  a_hdr_ver: assert property (rh |=> reg_rdata[19:16] == 4'h1)
    else $error("bad version");
  a_sel_write: assert property (sw |=> {24'h0, budget_sel} == ($past(reg_wdata) & 32'hFF))
    else $error("selector missed write");
  a_sel_hold: assert property (!sw |=> $stable(budget_sel))
    else $error("selector moved");
  a_data_zero: assert property (rd4 && budget_sel > 8'h01 |=> reg_rdata == 32'h0)
    else $error("unsupported entry not zero");
  a_data_rsvd: assert property (rd4 |=> reg_rdata[31:21] == 11'h0)
    else $error("data reserved bits set");
  a_type_max: assert property (rd4 && budget_sel == 8'h00 |=> reg_rdata[17:15] == 3'h7)
    else $error("bad max type");
  a_rail_id: assert property (rd4 && budget_sel < 8'h02 |=> reg_rdata[20:18] == 3'h2)
    else $error("bad rail");
  a_type_sust: assert property (rd4 && budget_sel == 8'h01 |=> reg_rdata[17:15] == 3'h1)
    else $error("bad sustained type");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without strobe");
endmodule
bind pbc_power_budget pbc_chk pbc_chk_inst (.core_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .budget_sel);

// >>> verif/tb_pbc_power_budget.sv
// self-checking bench for the power budget register group
// drives the register port and the sideband directly
`timescale 1ns/1ns
module tb_pbc_power_budget;
  reg         core_clk = 0, rstn = 0, upstream_port = 1;
  reg         reg_wr = 0, reg_rd = 0, ovr_wr = 0;
  reg  [11:0] reg_addr = 0, i;
  reg  [31:0] reg_wdata = 0;
  reg  [1:0]  ovr_sel = 0;
  reg  [7:0]  ovr_data = 0;
  wire [31:0] reg_rdata;
  wire [7:0]  budget_sel;
  integer     errors = 0, num_checks = 0;
  pbc_power_budget pbc_power_budget_inst (.core_clk, .rstn, .upstream_port, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ovr_wr, .ovr_sel, .ovr_data, .budget_sel);
  task check(input [39:0] what, input [31:0] seen, input [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("BAD %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk) reg_wr <= 0;
  endtask
  task ovr(input [1:0] s, input [7:0] d);
    @(posedge core_clk) {ovr_wr, ovr_sel, ovr_data} <= {1'b1, s, d};
    @(posedge core_clk) ovr_wr <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk) reg_rd <= 0;
    #1 check("rdata", reg_rdata, e);
  endtask
  // strap passes a synchroniser, so wait until it has settled after release
  task rst(input up);
    rstn <= 0;
    upstream_port <= up;
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    repeat (5) @(posedge core_clk);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2 core_clk = ~core_clk;
  initial
  begin
    #20000 errors = errors + 1;
    tally_and_finish;
  end
  initial
  begin
    rst(1);
    rd(12'h20C, 32'h23010004);
    rd(12'h214, 32'h000B8004);
    rd(12'h218, 32'h0);
    // ones everywhere, selector included, leaves it on an unsupported index
    for (i = 0; i < 4; i = i + 1)
      wr(12'h20C + (i << 2), 32'hFFFFFFFF);
    #1 check("sel", {24'h0, budget_sel}, 32'hFF);
    rd(12'h20C, 32'h23010004);
    rd(12'h210, 32'h000000FF);
    rd(12'h214, 32'h0);
    rd(12'h300, 32'h0);
    wr(12'h210, 32'hABCDEF01);
    #1 check("sel", {24'h0, budget_sel}, 32'h01);
    rd(12'h214, 32'h00088004);
    wr(12'h210, 32'h0);
    ovr(2'h0, 8'h10);
    ovr(2'h1, 8'h03);
    ovr(2'h2, 8'h02);
    ovr(2'h3, 8'h01);
    rd(12'h214, 32'h000BC310);
    rd(12'h218, 32'h1);
    wr(12'h210, 32'h00000005);
    rst(0);
    #1 check("sel", {24'h0, budget_sel}, 32'h00);
    rd(12'h20C, 32'h22010004);
    rd(12'h214, 32'h000B8004);
    rd(12'h218, 32'h0);
    tally_and_finish;
  end
endmodule

// >>> verilog/pbc_power_budget.v
// power budget extended capability register group of one switch port
// assumes a single core clock, a reset-synchronous-release port reset, and a
// sideband (serial management / eeprom loader) on the same clock driving overrides;
// the upstream strap comes from a pin and is synchronised here
`timescale 1ns/1ns
`include "pbc_regs.vh"

module pbc_power_budget
(
  // clock and reset
  input  wire                     core_clk,
  input  wire                     rstn,
  // port strap, sampled after reset release
  input  wire                     upstream_port,
  // register port
  input  wire [`PBC_ADDR_W-1:0]   reg_addr,
  input  wire [31:0]              reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [31:0]              reg_rdata,
  // sideband default override
  input  wire                     ovr_wr,
  input  wire [1:0]               ovr_sel,
  input  wire [7:0]               ovr_data,
  // current selector, for the rest of the port
  output reg  [`PBC_SEL_W-1:0]    budget_sel
);

////////////////////////////////////////////////////////////////////////////////
// storage

// defaults that the sideband may replace; software only ever reads them
reg  [7:0]               base_power;
reg  [1:0]               data_scale;
reg  [1:0]               pm_state;
reg                      sys_alloc;

// strap synchroniser stages and the settled port kind
reg                      strap_s1;
reg                      strap_s2;
reg                      strap_s3;
reg                      is_upstream;

// read path
reg  [31:0]              next_rdata;
wire [31:0]              hdr_word;
wire [31:0]              sel_word;
wire [31:0]              entry_word;
wire [31:0]              flag_word;

// write path
wire                     sel_write;

////////////////////////////////////////////////////////////////////////////////
// decode helpers

// register offset match; shared by the write path and the read mux
function hit_reg;
  input [`PBC_ADDR_W-1:0] addr;
  input [`PBC_ADDR_W-1:0] ofs;
  begin
    hit_reg = (addr == ofs);
  end
endfunction

// sideband target match; each default has its own update process
function ovr_hit;
  input                  wr;
  input [1:0]            sel;
  input [1:0]            target;
  begin
    ovr_hit = wr && (sel == target);
  end
endfunction

// only two entries exist; every other index reports an empty budget
function entry_known;
  input [`PBC_SEL_W-1:0] sel;
  begin
    entry_known = (sel == `PBC_SEL_MAX) || (sel == `PBC_SEL_SUST);
  end
endfunction

// assembles the data word for the selected entry
function [31:0] data_word;
  input [`PBC_SEL_W-1:0] sel;
  input [7:0]            base;
  input [1:0]            scale;
  input [1:0]            state;
  reg   [2:0]            kind;
  begin
    if (sel == `PBC_SEL_SUST)
      kind = `PBC_TYPE_SUST;
    else
      kind = `PBC_TYPE_MAX;
    if (entry_known(sel))
      data_word = {`PBC_DATA_PAD,
                   `PBC_RAIL_RST,
                   kind,
                   state,
                   `PBC_SUB_RST,
                   scale,
                   base};
    else
      data_word = `PBC_ZERO32;
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// port strap

// the strap is a pin level from outside the clock domain; three stages keep a
// metastable first stage away from the pointer logic
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    strap_s1 <= 1'b0;
    strap_s2 <= 1'b0;
    strap_s3 <= 1'b0;
  end
  else
  begin
    strap_s1 <= upstream_port;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end
end

// a strap change only counts once the last two stages agree; the pointer
// therefore settles a few cycles after reset release, not on the first edge
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    is_upstream <= 1'b0;
  else if (strap_s2 == strap_s3)
    is_upstream <= strap_s3;
end

////////////////////////////////////////////////////////////////////////////////
// software writes

// only the selector takes software writes; everything else is ignored
assign sel_write = reg_wr && hit_reg(reg_addr, `PBC_OFS_SELECT);

// upper write bits are dropped, so the reserved part can never be set
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    budget_sel <= `PBC_SEL_RST;
  else if (sel_write)
    budget_sel <= reg_wdata[`PBC_SEL_W-1:0];
end

////////////////////////////////////////////////////////////////////////////////
// sideband overrides

// base power in watts
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    base_power <= `PBC_BASE_RST;
  else if (ovr_hit(ovr_wr, ovr_sel, `PBC_OVR_BASE))
    base_power <= ovr_data;
end

// scale applied to the base power
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    data_scale <= `PBC_SCALE_RST;
  else if (ovr_hit(ovr_wr, ovr_sel, `PBC_OVR_SCALE))
    data_scale <= ovr_data[`PBC_NARROW_MSB:`PBC_FLAG_BIT];
end

// power-management state of the reported condition
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    pm_state <= `PBC_STATE_RST;
  else if (ovr_hit(ovr_wr, ovr_sel, `PBC_OVR_STATE))
    pm_state <= ovr_data[`PBC_NARROW_MSB:`PBC_FLAG_BIT];
end

// system-allocated flag; set by the loader when the platform already counts us
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    sys_alloc <= `PBC_SYS_RST;
  else if (ovr_hit(ovr_wr, ovr_sel, `PBC_OVR_SYSFLAG))
    sys_alloc <= ovr_data[`PBC_FLAG_BIT];
end

////////////////////////////////////////////////////////////////////////////////
// read words

// header: pointer, version and identifier are all fixed apart from the strap
assign hdr_word = {(is_upstream ? `PBC_NEXT_UP : `PBC_NEXT_DN),
                   `PBC_CAP_VER,
                   `PBC_CAP_ID};

// selector with its reserved upper part forced to zero
assign sel_word = {`PBC_SEL_PAD, budget_sel};

// budget entry picked by the selector
assign entry_word = data_word(budget_sel, base_power, data_scale, pm_state);

// system flag with its reserved upper part forced to zero
assign flag_word = {`PBC_FLAG_PAD, sys_alloc};

////////////////////////////////////////////////////////////////////////////////
// read mux

// unmapped offsets read as zero
always @*
begin
  next_rdata = `PBC_ZERO32;
  if (hit_reg(reg_addr, `PBC_OFS_HEADER))
  begin
    next_rdata = hdr_word;
  end
  else if (hit_reg(reg_addr, `PBC_OFS_SELECT))
  begin
    next_rdata = sel_word;
  end
  else if (hit_reg(reg_addr, `PBC_OFS_DATA))
  begin
    next_rdata = entry_word;
  end
  else if (hit_reg(reg_addr, `PBC_OFS_SYSFLAG))
  begin
    next_rdata = flag_word;
  end
  else
  begin
    next_rdata = `PBC_ZERO32;
  end
end

////////////////////////////////////////////////////////////////////////////////
// read data register

// read data stands only in the cycle after the strobe, zero otherwise; a
// quiet bus then never shows stale register contents
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    reg_rdata <= `PBC_ZERO32;
  end
  else if (reg_rd)
  begin
    reg_rdata <= next_rdata;
  end
  else
  begin
    reg_rdata <= `PBC_ZERO32;
  end
end

endmodule

// >>> verilog/pbc_regs.vh
// register offsets, field positions and reset values of the power budget capability group
// assumes a plain address/strobe register port with byte addresses, 32-bit data
`ifndef PBC_REGS_VH
`define PBC_REGS_VH

`define PBC_ADDR_W        12
`define PBC_OFS_HEADER    12'h20C
`define PBC_OFS_SELECT    12'h210
`define PBC_OFS_DATA      12'h214
`define PBC_OFS_SYSFLAG   12'h218
// sideband override port, offsets of our own
`define PBC_OVR_BASE      2'h0
`define PBC_OVR_SCALE     2'h1
`define PBC_OVR_STATE     2'h2
`define PBC_OVR_SYSFLAG   2'h3

`define PBC_CAP_ID        16'h0004
`define PBC_CAP_VER       4'h1
`define PBC_NEXT_UP       12'h230
`define PBC_NEXT_DN       12'h220

`define PBC_SEL_W         8
`define PBC_SEL_RST       8'h00
`define PBC_SEL_MAX       8'h00
`define PBC_SEL_SUST      8'h01

`define PBC_BASE_RST      8'h04
`define PBC_SCALE_RST     2'h0
`define PBC_SUB_RST       3'h0
`define PBC_STATE_RST     2'h0
`define PBC_TYPE_MAX      3'h7
`define PBC_TYPE_SUST     3'h1
`define PBC_RAIL_RST      3'h2
`define PBC_SYS_RST       1'h0

// padding used when words are assembled, and bit positions used when sideband data is taken
`define PBC_ZERO32        32'h00000000
`define PBC_SEL_PAD       24'h000000
`define PBC_DATA_PAD      11'h000
`define PBC_FLAG_PAD      31'h00000000
`define PBC_NARROW_MSB    1
`define PBC_FLAG_BIT      0

`endif
